// >>> core/cspcr_regs.sv
// Status word, power control and core configuration special-function registers
`timescale 1ns/1ps
// Summary of operation
// - Status word at D0H, reset 00H, bit-addressable
// - Status bits: carry, aux, flags, bank, overflow, parity
// - Power control at 87H, reset 00H
// - Bit 7 doubles the serial baud rate
// - Bit 6 lets serial interrupts end power-down
// - Bit 5 lets external line end power-down
// - Bit 4 disables the address latch strobe
// - Bit 1 enters power-down mode
// - Bits 3,2 spare flags; bit 0 unimplemented
// - Configuration at AFH, reset 00H
// - Reset gives legacy mode; bits 6..1 unimplemented
// - Bit 7 set: stack carries into upper byte
// - Bit 7 clear: stack wraps FFH to 00H
// - Bit 0 maps on-chip RAM into low 2k
// - Bit 0 clear: full external space used
// - Upper stack byte: 3 bits, gated by bit 7
module cspcr_regs
  import cspcr_pkg::*;
(
  input  wire logic        clock_i,          // Core clock
  input  wire logic        rstn_i,           // Asynchronous reset, active low
  input  wire logic [7:0]  sfr_addr_i,       // Direct special-function address
  input  wire logic        sfr_wr_i,         // Byte write strobe
  input  wire logic [7:0]  sfr_wdata_i,      // Byte write data
  input  wire logic        sfr_bit_wr_i,     // Bit write strobe (status word)
  input  wire logic [2:0]  sfr_bit_sel_i,    // Bit position for bit write
  input  wire logic        sfr_bit_val_i,    // Bit value for bit write
  input  wire logic        sfr_rd_i,         // Read strobe
  input  wire logic [7:0]  acc_i,            // Accumulator for parity
  input  wire logic        alu_flag_we_i,    // Core updates arithmetic flags
  input  wire logic        alu_carry_i,      // New carry
  input  wire logic        alu_auxc_i,       // New low-nibble carry
  input  wire logic        alu_ovf_i,        // New overflow
  input  wire logic        sp_push_i,        // Stack pre-increment
  input  wire logic        sp_pop_i,         // Stack post-decrement
  input  wire logic [23:0] xdata_addr_i,     // External data address
  input  wire logic        serial_irq_i,     // Serial unit interrupt
  input  wire logic        ext_irq0_line_i,  // External interrupt line
  input  wire logic        ext_irq0_edge_select_i, // 1: falling edge, 0: low level
  output logic [7:0]       sfr_rdata_o,      // Read data
  output logic             sfr_hit_o,        // Address belongs to this block
  output logic [1:0]       bank_sel_o,       // Active working register bank
  output logic [10:0]      stack_addr_o,     // Stack pointer, widened
  output logic             baud_doubler_o,   // Double the serial baud rate
  output logic             latch_strobe_en_o,// Address latch strobe enable
  output logic             power_down_o,     // Power-down mode
  output logic             wake_o,           // Wake pulse
  output logic             xdata_onchip_o    // Access goes to on-chip RAM
);

  logic [7:0]  psw_q;       // Status word
  logic [7:0]  pwr_q;       // Power control
  logic [7:0]  cfg_q;       // Configuration
  logic [7:0]  sp_lo_q;     // Stack pointer low byte
  logic [2:0]  sp_hi_q;     // Stack pointer upper bits
  logic [7:0]  rdata_d;     // Read mux
  logic        hit_d;       // Address decode
  logic        parity;      // Even/odd indicator from accumulator
  logic        sp_hi_vis;   // Upper stack register reachable
  logic [10:0] sp_full;     // Joined stack pointer
  logic [10:0] sp_next;     // Stack pointer after push or pop
  logic        pd_set;      // Power-down request strobe
  logic        wr_pwr;      // Byte write to power control
  logic        pd_now;      // Power-down state from wake unit
  logic        wake_now;    // Wake pulse from wake unit

  assign parity    = ^acc_i;
  assign sp_hi_vis = cfg_q[CSPCR_CFG_SWIDE];
  assign sp_full   = {sp_hi_q, sp_lo_q};
  assign wr_pwr    = sfr_wr_i && (sfr_addr_i == CSPCR_ADDR_PWR);
  assign pd_set    = wr_pwr && sfr_wdata_i[CSPCR_PWR_PDREQ];

  // Stack step: wide carries into upper bits, narrow wraps in 8 bits
  always_comb
  begin
    sp_next = sp_full;
    if (cfg_q[CSPCR_CFG_SWIDE])
    begin
      if (sp_push_i)
        sp_next = sp_full + 11'h001;
      else if (sp_pop_i)
        sp_next = sp_full - 11'h001;
    end
    else
    begin
      if (sp_push_i)
        sp_next = {3'h0, sp_lo_q + 8'h01};
      else if (sp_pop_i)
        sp_next = {3'h0, sp_lo_q - 8'h01};
    end
  end

  // Status word: byte write, bit write, core flag updates
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      psw_q <= CSPCR_RST_PSW;
    else
    begin
      if (sfr_wr_i && sfr_addr_i == CSPCR_ADDR_PSW)
        psw_q <= sfr_wdata_i;
      else if (sfr_bit_wr_i && sfr_addr_i == CSPCR_ADDR_PSW)
        psw_q[sfr_bit_sel_i] <= sfr_bit_val_i;
      else if (alu_flag_we_i)
      begin
        psw_q[CSPCR_PSW_CARRY] <= alu_carry_i;
        psw_q[CSPCR_PSW_AUXC]  <= alu_auxc_i;
        psw_q[CSPCR_PSW_OVF]   <= alu_ovf_i;
      end
    end
  end

  // Power control: bit 0 never stored
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pwr_q <= CSPCR_RST_PWR;
    else if (wr_pwr)
      pwr_q <= sfr_wdata_i & CSPCR_PWR_WMASK;
    else if (pwr_q[CSPCR_PWR_PDREQ] && wake_now)
      pwr_q[CSPCR_PWR_PDREQ] <= 1'b0;
  end

  // Configuration: only bits 7 and 0 exist
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cfg_q <= CSPCR_RST_CFG;
    else if (sfr_wr_i && sfr_addr_i == CSPCR_ADDR_CFG)
      cfg_q <= sfr_wdata_i & CSPCR_CFG_WMASK;
  end

  // Stack pointer: writes win over push and pop
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sp_lo_q <= CSPCR_RST_SPLO;
      sp_hi_q <= CSPCR_RST_SPHI;
    end
    else
    begin
      sp_lo_q <= sp_next[7:0];
      sp_hi_q <= sp_next[10:8];
      if (sfr_wr_i && sfr_addr_i == CSPCR_ADDR_SPLO)
        sp_lo_q <= sfr_wdata_i;
      if (sfr_wr_i && sfr_addr_i == CSPCR_ADDR_SPHI && sp_hi_vis)
        sp_hi_q <= sfr_wdata_i[2:0];
      if (!sp_hi_vis)
        sp_hi_q <= 3'h0;
    end
  end

  // Read mux and decode; upper stack byte hidden when narrow
  always_comb
  begin
    rdata_d = 8'h00;
    hit_d   = 1'b1;
    unique case (sfr_addr_i)
      CSPCR_ADDR_PSW:  rdata_d = {psw_q[7:1], parity};
      CSPCR_ADDR_PWR:  rdata_d = pwr_q;
      CSPCR_ADDR_CFG:  rdata_d = cfg_q;
      CSPCR_ADDR_SPLO: rdata_d = sp_lo_q;
      CSPCR_ADDR_SPHI:
      begin
        hit_d   = sp_hi_vis;
        rdata_d = sp_hi_vis ? {5'h00, sp_hi_q} : 8'h00;
      end
      default:         hit_d   = 1'b0;
    endcase
  end

  // Registered outputs
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sfr_rdata_o       <= 8'h00;
      sfr_hit_o         <= 1'b0;
      bank_sel_o        <= 2'h0;
      stack_addr_o      <= 11'h000;
      baud_doubler_o    <= 1'b0;
      latch_strobe_en_o <= 1'b1;
      xdata_onchip_o    <= 1'b0;
    end
    else
    begin
      sfr_rdata_o       <= sfr_rd_i ? rdata_d : 8'h00;
      sfr_hit_o         <= sfr_rd_i & hit_d;
      bank_sel_o        <= {psw_q[CSPCR_PSW_BSH], psw_q[CSPCR_PSW_BSL]};
      stack_addr_o      <= sp_full;
      baud_doubler_o    <= pwr_q[CSPCR_PWR_BAUD2];
      latch_strobe_en_o <= ~pwr_q[CSPCR_PWR_LSOFF];
      xdata_onchip_o    <= cfg_q[CSPCR_CFG_XMAP]
                           && (xdata_addr_i <= CSPCR_XMAP_TOP);
    end
  end

  // Power-down entry and wake detection
  cspcr_wake u_wake (
    .clock_i          (clock_i),
    .rstn_i           (rstn_i),
    .pd_set_i         (pd_set),
    .serial_wake_en_i (pwr_q[CSPCR_PWR_SERWK]),
    .irq0_wake_en_i   (pwr_q[CSPCR_PWR_IRQWK]),
    .edge_sel_i       (ext_irq0_edge_select_i),
    .serial_irq_i     (serial_irq_i),
    .ext_irq0_line_i  (ext_irq0_line_i),
    .power_down_o     (pd_now),
    .wake_o           (wake_now)
  );

  assign power_down_o = pd_now;
  assign wake_o       = wake_now;

endmodule

// >>> core/cspcr_pkg.sv
// Package with addresses, field positions and reset values of the core status registers
package cspcr_pkg;

  // Special-function addresses
  localparam logic [7:0] CSPCR_ADDR_PSW   = 8'hd0;
  localparam logic [7:0] CSPCR_ADDR_PWR   = 8'h87;
  localparam logic [7:0] CSPCR_ADDR_CFG   = 8'haf;
  localparam logic [7:0] CSPCR_ADDR_SPLO  = 8'h81;
  localparam logic [7:0] CSPCR_ADDR_SPHI  = 8'hb7;

  // Reset values
  localparam logic [7:0] CSPCR_RST_PSW    = 8'h00;
  localparam logic [7:0] CSPCR_RST_PWR    = 8'h00;
  localparam logic [7:0] CSPCR_RST_CFG    = 8'h00;
  localparam logic [7:0] CSPCR_RST_SPLO   = 8'h07;
  localparam logic [2:0] CSPCR_RST_SPHI   = 3'h0;

  // Status word fields
  localparam int CSPCR_PSW_CARRY = 7;
  localparam int CSPCR_PSW_AUXC  = 6;
  localparam int CSPCR_PSW_UF0   = 5;
  localparam int CSPCR_PSW_BSH   = 4;
  localparam int CSPCR_PSW_BSL   = 3;
  localparam int CSPCR_PSW_OVF   = 2;
  localparam int CSPCR_PSW_UF1   = 1;
  localparam int CSPCR_PSW_PAR   = 0;

  // Power control fields
  localparam int CSPCR_PWR_BAUD2 = 7;
  localparam int CSPCR_PWR_SERWK = 6;
  localparam int CSPCR_PWR_IRQWK = 5;
  localparam int CSPCR_PWR_LSOFF = 4;
  localparam int CSPCR_PWR_SPF1  = 3;
  localparam int CSPCR_PWR_SPF0  = 2;
  localparam int CSPCR_PWR_PDREQ = 1;
  localparam logic [7:0] CSPCR_PWR_WMASK = 8'hfe;

  // Configuration fields
  localparam int CSPCR_CFG_SWIDE = 7;
  localparam int CSPCR_CFG_XMAP  = 0;
  localparam logic [7:0] CSPCR_CFG_WMASK = 8'h81;

  // Extended data map limit: lowest 2 kbytes
  localparam logic [23:0] CSPCR_XMAP_TOP = 24'h0007ff;

endpackage

// >>> core/cspcr_wake.sv
// Power-down state holder with wake-up source detection
`timescale 1ns/1ps
module cspcr_wake
  import cspcr_pkg::*;
(
  input  wire logic clock_i,          // Core clock
  input  wire logic rstn_i,           // Asynchronous reset, active low
  input  wire logic pd_set_i,         // Power-down request written
  input  wire logic serial_wake_en_i, // Serial unit wake enabled
  input  wire logic irq0_wake_en_i,   // External line wake enabled
  input  wire logic edge_sel_i,       // 1: falling edge, 0: low level
  input  wire logic serial_irq_i,     // Serial unit interrupt
  input  wire logic ext_irq0_line_i,  // External interrupt line
  output logic      power_down_o,     // Device is in power-down
  output logic      wake_o            // One-cycle wake pulse
);

  logic line_prev_q;  // Last sample of the external line
  logic wake_cond;    // Any enabled wake source active

  // Track the line for falling-edge detection
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      line_prev_q <= 1'b1;
    else
      line_prev_q <= ext_irq0_line_i;
  end

  // Wake on serial interrupt, line level or falling edge
  always_comb
  begin
    wake_cond = serial_wake_en_i & serial_irq_i;
    if (irq0_wake_en_i)
    begin
      if (edge_sel_i)
        wake_cond = wake_cond | (line_prev_q & ~ext_irq0_line_i);
      else
        wake_cond = wake_cond | ~ext_irq0_line_i;
    end
  end

  // Power-down state: entered on request, left on wake
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      power_down_o <= 1'b0;
      wake_o       <= 1'b0;
    end
    else
    begin
      wake_o <= power_down_o & wake_cond;
      if (pd_set_i)
        power_down_o <= 1'b1;
      else if (power_down_o && wake_cond)
        power_down_o <= 1'b0;
    end
  end

endmodule

// >>> dv/cspcr_assertions.sv
// Port checker for the status, power control and configuration registers
`timescale 1ns/1ps
module cspcr_chk
  import cspcr_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        rstn_i,
  input wire logic [7:0]  sfr_addr_i,
  input wire logic        sfr_wr_i,
  input wire logic [7:0]  sfr_wdata_i,
  input wire logic        sfr_rd_i,
  input wire logic [7:0]  acc_i,
  input wire logic [23:0] xdata_addr_i,
  input wire logic [7:0]  sfr_rdata_o,
  input wire logic        sfr_hit_o,
  input wire logic [1:0]  bank_sel_o,
  input wire logic        baud_doubler_o,
  input wire logic        latch_strobe_en_o,
  input wire logic        power_down_o,
  input wire logic        wake_o,
  input wire logic        xdata_onchip_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  // Decoded strobes and parity of the accumulator
  wire psw_w = sfr_wr_i && sfr_addr_i == CSPCR_ADDR_PSW;
  wire pwr_w = sfr_wr_i && sfr_addr_i == CSPCR_ADDR_PWR;
  wire pd_w  = pwr_w && sfr_wdata_i[1];
  wire par   = ^acc_i;
  property p_bank; psw_w |-> ##2 bank_sel_o == $past(sfr_wdata_i[4:3], 2); endproperty
  a_bank: assert property (p_bank) else $error("bank select mismatch");
  property p_baud; pwr_w |-> ##2 baud_doubler_o == $past(sfr_wdata_i[7], 2); endproperty
  a_baud: assert property (p_baud) else $error("baud doubling mismatch");
  property p_latch; pwr_w |-> ##2 latch_strobe_en_o != $past(sfr_wdata_i[4], 2); endproperty
  a_latch: assert property (p_latch) else $error("latch strobe mismatch");
  property p_hit; sfr_rd_i && (sfr_addr_i == CSPCR_ADDR_PSW || sfr_addr_i == CSPCR_ADDR_PWR
    || sfr_addr_i == CSPCR_ADDR_CFG) |=> sfr_hit_o; endproperty
  a_hit: assert property (p_hit) else $error("register read not claimed");
  property p_cfg; sfr_rd_i && sfr_addr_i == CSPCR_ADDR_CFG |=> (sfr_rdata_o & 8'h7e) == 8'h00;
  endproperty
  a_cfg: assert property (p_cfg) else $error("configuration spare bits set");
  property p_pwr0; sfr_rd_i && sfr_addr_i == CSPCR_ADDR_PWR |=> !sfr_rdata_o[0]; endproperty
  a_pwr0: assert property (p_pwr0) else $error("power control bit 0 set");
  property p_par; sfr_rd_i && sfr_addr_i == CSPCR_ADDR_PSW |=> sfr_rdata_o[0] == $past(par);
  endproperty
  a_par: assert property (p_par) else $error("parity bit mismatch");
  property p_xmap; xdata_onchip_o |-> $past(xdata_addr_i) <= CSPCR_XMAP_TOP; endproperty
  a_xmap: assert property (p_xmap) else $error("on-chip map above 2k");
  property p_pd; $rose(power_down_o) |-> $past(pd_w); endproperty
  a_pd: assert property (p_pd) else $error("power-down without request");
  property p_wake; wake_o |-> !power_down_o ##1 !wake_o; endproperty
  a_wake: assert property (p_wake) else $error("wake pulse malformed");
endmodule

bind cspcr_regs cspcr_chk chk_u (.clock_i, .rstn_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
  .sfr_rd_i, .acc_i, .xdata_addr_i, .sfr_rdata_o, .sfr_hit_o, .bank_sel_o, .baud_doubler_o,
  .latch_strobe_en_o, .power_down_o, .wake_o, .xdata_onchip_o);

// >>> dv/tb.sv
// Self-checking bench for the status, power control and configuration registers
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module tb;
  import cspcr_pkg::*;
  logic        clock_i, rstn_i, sfr_wr_i, sfr_bit_wr_i, sfr_bit_val_i, sfr_rd_i;
  logic        alu_flag_we_i, alu_carry_i, alu_auxc_i, alu_ovf_i, sp_push_i, sp_pop_i;
  logic        serial_irq_i, ext_irq0_line_i, ext_irq0_edge_select_i, sfr_hit_o;
  logic        baud_doubler_o, latch_strobe_en_o, power_down_o, wake_o, xdata_onchip_o;
  logic [7:0]  sfr_addr_i, sfr_wdata_i, acc_i, sfr_rdata_o, v;
  logic [2:0]  sfr_bit_sel_i;
  logic [1:0]  bank_sel_o;
  logic [10:0] stack_addr_o;
  logic [23:0] xdata_addr_i;
  logic [31:0] rnd;
  int          n_mismatch, cmp_count;
  cspcr_regs dut_u (.clock_i, .rstn_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_bit_wr_i,
    .sfr_bit_sel_i, .sfr_bit_val_i, .sfr_rd_i, .acc_i, .alu_flag_we_i, .alu_carry_i,
    .alu_auxc_i, .alu_ovf_i, .sp_push_i, .sp_pop_i, .xdata_addr_i, .serial_irq_i,
    .ext_irq0_line_i, .ext_irq0_edge_select_i, .sfr_rdata_o, .sfr_hit_o, .bank_sel_o,
    .stack_addr_o, .baud_doubler_o, .latch_strobe_en_o, .power_down_o, .wake_o,
    .xdata_onchip_o);
  // Random source
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Expected status word: bit 0 is accumulator parity
  function automatic logic [7:0] psw_exp(input logic [7:0] s, input logic [7:0] a);
    return {s[7:1], ^a};
  endfunction
  // Byte write, then settle past the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i) begin sfr_wr_i <= 1; sfr_addr_i <= a; sfr_wdata_i <= d; end
    @(posedge clock_i) sfr_wr_i <= 0;
    #1;
  endtask
  // Read with expected data and hit one cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    @(posedge clock_i) begin sfr_rd_i <= 1; sfr_addr_i <= a; end
    @(posedge clock_i) sfr_rd_i <= 0;
    #1 `CHK({sfr_hit_o, sfr_rdata_o}, {h, e})
  endtask
  // Single push or pop, then let the pointer settle
  task automatic sp(input logic up);
    @(posedge clock_i) if (up) sp_push_i <= 1; else sp_pop_i <= 1;
    @(posedge clock_i) {sp_push_i, sp_pop_i} <= 2'b00;
    repeat (2) @(posedge clock_i);
    #1;
  endtask
  // Verdict
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clock_i = 0;
    forever #5 clock_i = ~clock_i;
  end
  // Watchdog well beyond the expected run
  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
  initial begin
    {rstn_i, sfr_wr_i, sfr_bit_wr_i, sfr_bit_val_i, sfr_rd_i, alu_flag_we_i} = '0;
    {alu_carry_i, alu_auxc_i, alu_ovf_i, sp_push_i, sp_pop_i, serial_irq_i} = '0;
    {sfr_addr_i, sfr_wdata_i, acc_i, sfr_bit_sel_i, xdata_addr_i} = '0;
    ext_irq0_line_i = 1;
    ext_irq0_edge_select_i = 0;
    rnd = 32'h9e09ef6c;
    repeat (5) @(posedge clock_i);
    rstn_i <= 1;
    rd(CSPCR_ADDR_PSW, 8'h00, 1);
    rd(CSPCR_ADDR_PWR, 8'h00, 1);
    rd(CSPCR_ADDR_CFG, 8'h00, 1);
    rd(8'h86, 8'h00, 0);
    for (int i = 0; i < 24; i++)
    begin
      rnd = lfsr(rnd);
      v = rnd[7:0];
      @(posedge clock_i) begin acc_i <= rnd[15:8];
        xdata_addr_i <= (i < 4) ? 24'h0007fe + 24'(i) : {8'h00, rnd[31:16]}; end
      wr(CSPCR_ADDR_PSW, v);
      rd(CSPCR_ADDR_PSW, psw_exp(v, acc_i), 1);
      `CHK(bank_sel_o, v[4:3])
      @(posedge clock_i) begin sfr_bit_wr_i <= 1; sfr_bit_sel_i <= rnd[18:16];
        sfr_bit_val_i <= rnd[19]; sfr_addr_i <= CSPCR_ADDR_PSW; end
      @(posedge clock_i) begin sfr_bit_wr_i <= 0; alu_flag_we_i <= 1;
        {alu_carry_i, alu_auxc_i, alu_ovf_i} <= rnd[22:20]; end
      @(posedge clock_i) alu_flag_we_i <= 0;
      v[rnd[18:16]] = rnd[19];
      {v[7], v[6], v[2]} = rnd[22:20];
      rd(CSPCR_ADDR_PSW, psw_exp(v, acc_i), 1);
      wr(CSPCR_ADDR_PWR, v & 8'hfd);
      rd(CSPCR_ADDR_PWR, v & 8'hfc, 1);
      `CHK({baud_doubler_o, latch_strobe_en_o}, {v[7], ~v[4]})
      wr(CSPCR_ADDR_CFG, v);
      rd(CSPCR_ADDR_CFG, v & 8'h81, 1);
      `CHK(xdata_onchip_o, v[0] && xdata_addr_i <= 24'h0007ff)
    end
    wr(CSPCR_ADDR_CFG, 8'h00);
    wr(CSPCR_ADDR_SPLO, 8'hff);
    sp(1);
    `CHK(stack_addr_o, 11'h000)
    rd(CSPCR_ADDR_SPHI, 8'h00, 0);
    wr(CSPCR_ADDR_CFG, 8'h80);
    wr(CSPCR_ADDR_SPLO, 8'hff);
    sp(1);
    `CHK(stack_addr_o, 11'h100)
    sp(0);
    `CHK(stack_addr_o, 11'h0ff)
    wr(CSPCR_ADDR_SPHI, 8'hfe);
    rd(CSPCR_ADDR_SPHI, 8'h06, 1);
    for (int m = 0; m < 3; m++)
    begin
      @(posedge clock_i) ext_irq0_edge_select_i <= (m == 1);
      wr(CSPCR_ADDR_PWR, (m == 2) ? 8'h42 : 8'h22);
      `CHK(power_down_o, 1'b1)
      @(posedge clock_i) if (m == 2) serial_irq_i <= 1; else ext_irq0_line_i <= 0;
      @(posedge clock_i) #1;
      `CHK({power_down_o, wake_o}, 2'b01)
      @(posedge clock_i) begin serial_irq_i <= 0; ext_irq0_line_i <= 1; end
      #1 `CHK(wake_o, 1'b0)
      rd(CSPCR_ADDR_PWR, (m == 2) ? 8'h40 : 8'h20, 1);
    end
    close_out();
  end
endmodule
